// [src/ibs_device_end.sv]
/*
 * Device end of the byte stream port: makes the port clock, runs the
 * transmit fetch and the receive delivery, buffers fetched bytes.
 * Assumes the far end samples strobes on the falling port clock edge
 * and changes its own outputs there.
 */
`timescale 1ns/1ps
module ibs_device_end (
    input wire logic mclk,
    input wire logic reset,
    ibs_if.device port,
    input wire logic tx_req_valid,
    input wire logic [ibs_pkg::LEN_W-1:0] tx_req_len,
    output logic tx_req_ready,
    output logic tx_out_valid,
    output logic [ibs_pkg::BYTE_W-1:0] tx_out_data,
    input wire logic tx_out_ready,
    input wire logic rx_in_valid,
    input wire logic [ibs_pkg::BYTE_W-1:0] rx_in_data,
    input wire logic rx_in_first,
    input wire logic [ibs_pkg::LEN_W-1:0] rx_in_len,
    input wire logic [ibs_pkg::SYNC_W-1:0] rx_in_sync,
    input wire logic rx_in_error,
    output logic rx_in_ready,
    input wire logic [ibs_pkg::SYNC_W-1:0] receive_sync_mask,
    output logic tx_active
);
    logic [ibs_pkg::DIV_W-1:0] cnt_q, cnt_d;
    logic pclk_q, pclk_d;
    logic tick;
    logic [ibs_pkg::SYNC_VEC_W-1:0] sync1_q, sync2_q;
    logic rdy_s, engine_n_s;
    logic [ibs_pkg::BYTE_W-1:0] data_s;
    ibs_pkg::ibs_state_e state_q, state_d;
    logic [ibs_pkg::LEN_W-1:0] idx_q, idx_d, len_q, len_d;
    logic clr_q, clr_d, adv_q, adv_d, flag_q, flag_d;
    logic done_n_q, done_n_d, err_q, err_d, doe_q, doe_d;
    logic [ibs_pkg::BYTE_W-1:0] dout_q, dout_d;
    logic push, fifo_in_ready, in_tx, last_byte, sync_hit;

    function automatic logic boundary(
        input logic [ibs_pkg::LEN_W-1:0] idx,
        input logic [ibs_pkg::LEN_W-1:0] len
    );
        logic [ibs_pkg::LEN_W:0] i;
        i = {1'b0, idx};
        boundary = (i < ibs_pkg::QUAD_BYTES) ||
                   (i + ibs_pkg::QUAD_BYTES >= {1'b0, len});
    endfunction : boundary

    // Far-end inputs are asynchronous to mclk, so all pass two flops.
    assign rdy_s = sync2_q[ibs_pkg::BYTE_W+1];
    assign engine_n_s = sync2_q[ibs_pkg::BYTE_W];
    assign data_s = sync2_q[ibs_pkg::BYTE_W-1:0];

    // Every port change except an engine-reset abort lands on the mclk edge that raises port_clock.
    assign tick = cnt_q == ibs_pkg::DIV_TICK;
    assign in_tx = (state_q == ibs_pkg::ST_TX_CLR) ||
                   (state_q == ibs_pkg::ST_TX_RUN) ||
                   (state_q == ibs_pkg::ST_TX_END);
    assign last_byte = idx_q == len_q - 1'b1;
    assign sync_hit = |(rx_in_sync & receive_sync_mask);
    assign tx_active = in_tx;

    always_comb begin
        cnt_d = (cnt_q == ibs_pkg::DIV_LAST) ? '0 : cnt_q + 1'b1;
        pclk_d = cnt_d >= ibs_pkg::DIV_HALF;
    end

    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        len_d = len_q;
        clr_d = clr_q;
        adv_d = adv_q;
        flag_d = flag_q;
        done_n_d = done_n_q;
        err_d = err_q;
        dout_d = dout_q;
        doe_d = doe_q;
        push = 1'b0;
        tx_req_ready = 1'b0;
        rx_in_ready = 1'b0;
        if (tick) begin
            clr_d = 1'b0;
            adv_d = 1'b0;
            flag_d = 1'b0;
            doe_d = 1'b0;
            case (state_q)
                ibs_pkg::ST_IDLE: begin
                    done_n_d = 1'b1;
                    if (rdy_s && engine_n_s && tx_req_valid &&
                        tx_req_len != '0) begin
                        tx_req_ready = 1'b1;
                        len_d = tx_req_len;
                        idx_d = '0;
                        clr_d = 1'b1;
                        done_n_d = 1'b0;
                        state_d = ibs_pkg::ST_TX_CLR;
                    end else if (rx_in_valid) begin
                        // Stray bytes outside a packet are dropped.
                        rx_in_ready = !rx_in_first || rx_in_len == '0;
                        if (rx_in_first && rx_in_len != '0) begin
                            len_d = rx_in_len;
                            idx_d = '0;
                            err_d = 1'b0;
                            if (sync_hit) begin
                                clr_d = 1'b1;
                                state_d = ibs_pkg::ST_RX_CLR;
                            end else begin
                                state_d = ibs_pkg::ST_RX_RUN;
                            end
                        end
                    end
                end
                ibs_pkg::ST_TX_CLR: begin
                    state_d = ibs_pkg::ST_TX_RUN;
                end
                ibs_pkg::ST_TX_RUN: begin
                    // A full FIFO holds advance low, so the far end waits.
                    if (fifo_in_ready) begin
                        adv_d = 1'b1;
                        push = 1'b1;
                        flag_d = boundary(idx_q, len_q);
                        idx_d = idx_q + 1'b1;
                        if (last_byte) begin
                            state_d = ibs_pkg::ST_TX_END;
                        end
                    end
                end
                ibs_pkg::ST_TX_END: begin
                    done_n_d = 1'b1;
                    if (!rdy_s) begin
                        state_d = ibs_pkg::ST_IDLE;
                    end
                end
                ibs_pkg::ST_RX_CLR: begin
                    state_d = ibs_pkg::ST_RX_RUN;
                end
                ibs_pkg::ST_RX_RUN: begin
                    if (rx_in_valid) begin
                        rx_in_ready = 1'b1;
                        adv_d = 1'b1;
                        doe_d = 1'b1;
                        dout_d = rx_in_data;
                        flag_d = boundary(idx_q, len_q);
                        err_d = err_q || rx_in_error;
                        idx_d = idx_q + 1'b1;
                        if (last_byte) begin
                            state_d = ibs_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = ibs_pkg::ST_IDLE;
                end
            endcase
        end
        // Receive states never look at the engine reset.
        if (!engine_n_s && in_tx) begin
            state_d = ibs_pkg::ST_IDLE;
            clr_d = 1'b0;
            adv_d = 1'b0;
            flag_d = 1'b0;
            done_n_d = 1'b1;
            push = 1'b0;
        end
    end

    ibs_fifo #(
        .WIDTH(ibs_pkg::BYTE_W),
        .DEPTH(ibs_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(mclk),
        .reset(reset),
        .in_valid(push),
        .in_data(data_s),
        .in_ready(fifo_in_ready),
        .out_valid(tx_out_valid),
        .out_data(tx_out_data),
        .out_ready(tx_out_ready)
    );

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
            pclk_q <= 1'b0;
            sync1_q <= ibs_pkg::RST_SYNC;
            sync2_q <= ibs_pkg::RST_SYNC;
            state_q <= ibs_pkg::ST_IDLE;
            idx_q <= '0;
            len_q <= '0;
            clr_q <= 1'b0;
            adv_q <= 1'b0;
            flag_q <= 1'b0;
            done_n_q <= ibs_pkg::RST_DONE_N;
            err_q <= 1'b0;
            dout_q <= '0;
            doe_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pclk_q <= pclk_d;
            sync1_q <= {port.ext_data_ready, port.stream_engine_reset_n,
                        port.port_data};
            sync2_q <= sync1_q;
            state_q <= state_d;
            idx_q <= idx_d;
            len_q <= len_d;
            clr_q <= clr_d;
            adv_q <= adv_d;
            flag_q <= flag_d;
            done_n_q <= done_n_d;
            err_q <= err_d;
            dout_q <= dout_d;
            doe_q <= doe_d;
        end
    end

    assign port.port_clock = pclk_q;
    assign port.transfer_complete_n = done_n_q;
    assign port.pointer_clear_pulse = clr_q;
    assign port.pointer_advance = adv_q;
    assign port.packet_boundary_flag = flag_q;
    assign port.rx_packet_error = err_q;
    assign port.dev_data_out = dout_q;
    assign port.dev_data_oe = doe_q;
endmodule : ibs_device_end

// [pkg/ibs_pkg.sv]
/*
 * Shared constants and types for the byte stream port: clock division,
 * widths, reset values and the port state encoding.
 * Assumes the device end runs on a 200 MHz mclk.
 */
package ibs_pkg;

    localparam int MCLK_PERIOD_NS = 5;
    localparam int PORT_CLOCK_PERIOD_NS = 40;
    localparam int PORT_DIV = PORT_CLOCK_PERIOD_NS / MCLK_PERIOD_NS;
    localparam int PORT_HALF = PORT_DIV / 2;
    localparam int DIV_W = 3;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PORT_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(PORT_HALF);
    localparam logic [DIV_W-1:0] DIV_TICK = DIV_W'(PORT_HALF - 1);

    localparam int BYTE_W = 8;
    localparam int LEN_W = 16;
    localparam int SYNC_W = 4;
    localparam int ADDR_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_VEC_W = BYTE_W + 2;
    localparam logic [LEN_W:0] QUAD_BYTES = 17'h00004;

    localparam logic RST_DONE_N = 1'b1;
    localparam logic RST_ENGINE_N = 1'b1;
    localparam logic [SYNC_VEC_W-1:0] RST_SYNC = 10'h100;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TX_CLR = 3'b001,
        ST_TX_RUN = 3'b011,
        ST_TX_END = 3'b010,
        ST_RX_RUN = 3'b110,
        ST_RX_CLR = 3'b100
    } ibs_state_e;

endpackage : ibs_pkg

// [pkg/ibs_if.sv]
/*
 * Link between the device end and the external buffer logic.
 * Assumes both ends drive the data bus only while their enable is high;
 * the bus indexes from 0, and line 0 carries the byte's top bit.
 */
`timescale 1ns/1ps
interface ibs_if;
    logic port_clock;
    logic transfer_complete_n;
    logic stream_engine_reset_n;
    logic ext_data_ready;
    logic pointer_clear_pulse;
    logic pointer_advance;
    logic packet_boundary_flag;
    logic rx_packet_error;
    logic [0:7] dev_data_out;
    logic dev_data_oe;
    logic [0:7] host_data_out;
    logic host_data_oe;
    logic [0:7] port_data;

    // An undriven bus reads as zero rather than floating.
    assign port_data = dev_data_oe ? dev_data_out :
                       (host_data_oe ? host_data_out : 8'h00);

    modport device (
        output port_clock,
        output transfer_complete_n,
        input stream_engine_reset_n,
        input ext_data_ready,
        output pointer_clear_pulse,
        output pointer_advance,
        output packet_boundary_flag,
        output rx_packet_error,
        output dev_data_out,
        output dev_data_oe,
        input port_data
    );

    modport host (
        input port_clock,
        input transfer_complete_n,
        output stream_engine_reset_n,
        output ext_data_ready,
        input pointer_clear_pulse,
        input pointer_advance,
        input packet_boundary_flag,
        input rx_packet_error,
        output host_data_out,
        output host_data_oe,
        input port_data
    );
endinterface : ibs_if

// [src/ibs_fifo.sv]
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes one clock; depth is a power of two.
 */
`timescale 1ns/1ps
module ibs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;

    // The extra pointer bit tells full from empty.
    assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule : ibs_fifo

// [src/ibs_host_end.sv]
/*
 * External buffer logic: a byte buffer with one address pointer that
 * feeds the device on transmit and stores its bytes on receive.
 * Assumes port_clock runs; all link logic runs on its falling edge.
 */
`timescale 1ns/1ps
module ibs_host_end (
    input wire logic reset,
    ibs_if.host port,
    input wire logic load_valid,
    input wire logic [ibs_pkg::ADDR_W-1:0] load_addr,
    input wire logic [ibs_pkg::BYTE_W-1:0] load_data,
    output logic load_ready,
    input wire logic data_available,
    input wire logic engine_reset,
    output logic rx_byte_valid,
    output logic [ibs_pkg::BYTE_W-1:0] rx_byte_data,
    output logic [ibs_pkg::ADDR_W-1:0] rx_byte_addr
);
    logic [ibs_pkg::BYTE_W-1:0] mem [2**ibs_pkg::ADDR_W];
    logic [ibs_pkg::ADDR_W-1:0] ptr_q, ptr_d, ptr_inc, rxa_q, rxa_d;
    logic [ibs_pkg::BYTE_W-1:0] txd_q, txd_d, rxd_q, rxd_d;
    logic oe_q, oe_d, rxv_q, rxv_d, we;
    logic rdy_q, rdy_d, busy_q, busy_d, wait_q, wait_d;
    logic eng_n_q, eng_n_d;
    // The control levels come from another clock, so each passes two flops.
    logic avail1_q, avail2_q, eng1_q;

    assign ptr_inc = ptr_q + 1'b1;
    assign load_ready = !we;

    always_comb begin
        ptr_d = ptr_q;
        txd_d = txd_q;
        rxd_d = rxd_q;
        rxa_d = rxa_q;
        rxv_d = 1'b0;
        we = 1'b0;
        oe_d = !port.transfer_complete_n;
        eng_n_d = !eng1_q;
        if (port.pointer_clear_pulse) begin
            ptr_d = '0;
            txd_d = mem[0];
        end else if (port.pointer_advance && !port.transfer_complete_n) begin
            ptr_d = ptr_inc;
            txd_d = mem[ptr_inc];
        end else if (port.pointer_advance) begin
            we = 1'b1;
            ptr_d = ptr_inc;
            rxv_d = 1'b1;
            rxd_d = port.port_data;
            rxa_d = ptr_q;
        end
        rdy_d = rdy_q;
        busy_d = busy_q;
        wait_d = wait_q;
        if (wait_q) begin
            wait_d = avail2_q;
        end else if (!rdy_q) begin
            rdy_d = avail2_q;
        end else if (!port.transfer_complete_n) begin
            busy_d = 1'b1;
        end else if (busy_q) begin
            // New data must be flagged afresh for the next block.
            rdy_d = 1'b0;
            busy_d = 1'b0;
            wait_d = 1'b1;
        end
    end

    always_ff @(negedge port.port_clock or posedge reset) begin
        if (reset) begin
            ptr_q <= '0;
            txd_q <= '0;
            rxd_q <= '0;
            rxa_q <= '0;
            rxv_q <= 1'b0;
            oe_q <= 1'b0;
            rdy_q <= 1'b0;
            busy_q <= 1'b0;
            wait_q <= 1'b0;
            eng_n_q <= ibs_pkg::RST_ENGINE_N;
            avail1_q <= 1'b0;
            avail2_q <= 1'b0;
            eng1_q <= 1'b0;
        end else begin
            avail1_q <= data_available;
            avail2_q <= avail1_q;
            eng1_q <= engine_reset;
            ptr_q <= ptr_d;
            txd_q <= txd_d;
            rxd_q <= rxd_d;
            rxa_q <= rxa_d;
            rxv_q <= rxv_d;
            oe_q <= oe_d;
            rdy_q <= rdy_d;
            busy_q <= busy_d;
            wait_q <= wait_d;
            eng_n_q <= eng_n_d;
        end
    end

    always_ff @(negedge port.port_clock) begin
        if (we) begin
            mem[ptr_q] <= port.port_data;
        end else if (load_valid) begin
            mem[load_addr] <= load_data;
        end
    end

    assign port.host_data_out = txd_q;
    assign port.host_data_oe = oe_q;
    assign port.ext_data_ready = rdy_q;
    assign port.stream_engine_reset_n = eng_n_q;
    assign rx_byte_valid = rxv_q;
    assign rx_byte_data = rxd_q;
    assign rx_byte_addr = rxa_q;
endmodule : ibs_host_end

// [testbench/ibs_link_monitor.sv]
/*
 * Concurrent checks on the link between the two ends of the port.
 * Assumes it sits beside the interface, sampled on the device mclk.
 */
`timescale 1ns/1ps
module ibs_link_monitor (
    input wire logic mclk,
    input wire logic reset,
    input wire logic port_clock,
    input wire logic transfer_complete_n,
    input wire logic stream_engine_reset_n,
    input wire logic ext_data_ready,
    input wire logic pointer_clear_pulse,
    input wire logic pointer_advance,
    input wire logic packet_boundary_flag,
    input wire logic rx_packet_error,
    input wire logic dev_data_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    a_port_clock_rate: assert property ($rose(port_clock) |->
        port_clock [*4] ##1 !port_clock [*4] ##1 port_clock)
        else $error("port clock period wrong");
    a_clear_one_period: assert property ($rose(pointer_clear_pulse) |->
        pointer_clear_pulse [*8] ##1 !pointer_clear_pulse)
        else $error("clear pulse not one port period");
    a_clear_on_tick: assert property ($rose(pointer_clear_pulse) |->
        $rose(port_clock))
        else $error("clear pulse off the rising port edge");
    // Abort is immediate by design, so moves under engine reset are exempt.
    a_advance_on_tick: assert property ($changed(pointer_advance) &&
        stream_engine_reset_n |-> $rose(port_clock))
        else $error("advance moved off the rising port edge");
    a_error_on_tick: assert property ($changed(rx_packet_error) |->
        $rose(port_clock))
        else $error("error flag moved off the rising port edge");
    a_tx_start_clear: assert property ($fell(transfer_complete_n) |->
        pointer_clear_pulse && !pointer_advance)
        else $error("transmit began without a clear pulse");
    a_tx_advance_low: assert property (pointer_advance && !dev_data_oe |->
        !transfer_complete_n)
        else $error("transmit advance while complete is high");
    a_rx_advance_drive: assert property (pointer_advance &&
        transfer_complete_n |-> dev_data_oe)
        else $error("receive advance without driven data");
    a_block_end_ready: assert property ($rose(transfer_complete_n) |->
        !pointer_advance ##[1:12] !ext_data_ready)
        else $error("block end handshake wrong");
    a_flag_in_advance: assert property (packet_boundary_flag |->
        pointer_advance)
        else $error("boundary flag outside a byte transfer");
    a_abort_at_once: assert property ($fell(stream_engine_reset_n) &&
        !transfer_complete_n |-> ##[1:5] transfer_complete_n &&
        !pointer_advance)
        else $error("engine reset did not abort transmit");

    c_tx_clear: cover property ($fell(transfer_complete_n));
    c_rx_clear: cover property ($rose(pointer_clear_pulse) &&
        transfer_complete_n);
    c_rx_error: cover property ($rose(rx_packet_error));
    c_abort: cover property ($fell(stream_engine_reset_n) &&
        !transfer_complete_n);
endmodule : ibs_link_monitor

// [testbench/test_isochronous_byte_stream_port.sv]
/*
 * Self-checking bench joining both port ends: block transmits with a
 * stall and an abort, and receive packets with and without sync match.
 * Assumes the device end makes the port clock from mclk.
 */
`timescale 1ns/1ps
module test_isochronous_byte_stream_port;
    logic mclk, reset, tx_req_valid, tx_req_ready, tx_out_valid;
    logic tx_out_ready, tx_active, rx_in_valid, rx_in_first, rx_in_error;
    logic rx_in_ready, load_valid, load_ready, data_available;
    logic engine_reset, rx_byte_valid;
    logic [ibs_pkg::LEN_W-1:0] tx_req_len, rx_in_len;
    logic [7:0] tx_out_data, rx_in_data, load_addr, load_data;
    logic [7:0] rx_byte_data, rx_byte_addr;
    logic [3:0] rx_in_sync, sync_mask;
    logic [7:0] rx_wire[$], rx_host[$], rx_addr[$];
    int n_mismatch = 0, compares = 0, adv_n = 0, flag_n = 0, clr_n = 0;
    int a0, f0, c0, k;

    ibs_if link();
    ibs_device_end ibs_device_end_i (.mclk(mclk), .reset(reset),
        .port(link), .tx_req_valid(tx_req_valid), .tx_req_len(tx_req_len),
        .tx_req_ready(tx_req_ready), .tx_out_valid(tx_out_valid),
        .tx_out_data(tx_out_data), .tx_out_ready(tx_out_ready),
        .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data),
        .rx_in_first(rx_in_first), .rx_in_len(rx_in_len),
        .rx_in_sync(rx_in_sync), .rx_in_error(rx_in_error),
        .rx_in_ready(rx_in_ready), .receive_sync_mask(sync_mask),
        .tx_active(tx_active));
    ibs_host_end ibs_host_end_i (.reset(reset), .port(link),
        .load_valid(load_valid), .load_addr(load_addr),
        .load_data(load_data), .load_ready(load_ready),
        .data_available(data_available), .engine_reset(engine_reset),
        .rx_byte_valid(rx_byte_valid), .rx_byte_data(rx_byte_data),
        .rx_byte_addr(rx_byte_addr));
    ibs_link_monitor ibs_link_monitor_i (.mclk(mclk), .reset(reset),
        .port_clock(link.port_clock),
        .transfer_complete_n(link.transfer_complete_n),
        .stream_engine_reset_n(link.stream_engine_reset_n),
        .ext_data_ready(link.ext_data_ready),
        .pointer_clear_pulse(link.pointer_clear_pulse),
        .pointer_advance(link.pointer_advance),
        .packet_boundary_flag(link.packet_boundary_flag),
        .rx_packet_error(link.rx_packet_error),
        .dev_data_oe(link.dev_data_oe));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Strobes are settled at the falling port edge, so count them there.
    always @(negedge link.port_clock) begin
        if (link.pointer_advance === 1'b1) adv_n++;
        if ((link.pointer_advance & link.packet_boundary_flag) === 1'b1)
            flag_n++;
        if (link.pointer_clear_pulse === 1'b1) clr_n++;
        if ((link.pointer_advance & link.transfer_complete_n) === 1'b1)
            rx_wire.push_back(link.port_data);
        if (rx_byte_valid === 1'b1) begin
            rx_host.push_back(rx_byte_data);
            rx_addr.push_back(rx_byte_addr);
        end
    end

    task automatic chk(input string what, input logic [15:0] seen,
            input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    function automatic int flags(input int len);
        int i, n;
        n = 0;
        for (i = 0; i < len; i++) if (i < 4 || i >= len - 4) n++;
        return n;
    endfunction : flags

    task automatic load(input logic [7:0] a);
        int j;
        load_addr = a;
        load_data = 8'h81 ^ a;
        load_valid = 1'b1;
        for (j = 0; j < 40; j++) begin
            @(negedge link.port_clock);
            if (load_ready === 1'b1) break;
        end
        step(1);
        load_valid = 1'b0;
        step(1);
    endtask : load

    task automatic tx_start(input int len);
        int j;
        data_available = 1'b0;
        step(24);
        data_available = 1'b1;
        a0 = adv_n;
        f0 = flag_n;
        c0 = clr_n;
        tx_req_len = len;
        tx_req_valid = 1'b1;
        for (j = 0; j < 400; j++) begin
            @(posedge mclk);
            if (tx_req_ready === 1'b1) break;
        end
        #1;
        tx_req_valid = 1'b0;
    endtask : tx_start

    task automatic tx_collect(input int len);
        int i, j;
        i = 0;
        tx_out_ready = 1'b1;
        for (j = 0; j < 3000 && i < len; j++) begin
            @(posedge mclk);
            if (tx_out_valid === 1'b1) begin
                chk("tx byte", tx_out_data, 8'h81 ^ i[7:0]);
                i++;
            end
        end
        step(1);
        for (j = 0; j < 400 && tx_active !== 1'b0; j++) step(1);
        chk("tx advances", adv_n - a0, len);
        chk("tx flags", flag_n - f0, flags(len));
        chk("tx clears", clr_n - c0, 1);
        chk("complete at end", link.transfer_complete_n, 1'b1);
    endtask : tx_collect

    task automatic rx_packet(input int len, input logic [3:0] sync,
            input int errpos, input int clr);
        int i, j;
        c0 = clr_n;
        f0 = flag_n;
        rx_wire.delete();
        rx_host.delete();
        rx_addr.delete();
        rx_in_len = len;
        rx_in_sync = sync;
        rx_in_valid = 1'b1;
        for (i = 0; i < len; i++) begin
            rx_in_data = 8'h4c + i[7:0];
            rx_in_first = (i == 0);
            rx_in_error = (i == errpos);
            for (j = 0; j < 400; j++) begin
                @(posedge mclk);
                if (rx_in_ready === 1'b1) break;
            end
            #1;
        end
        rx_in_valid = 1'b0;
        for (j = 0; j < 40 && rx_host.size() < len; j++)
            @(negedge link.port_clock);
        step(1);
        chk("rx count", rx_host.size(), len);
        for (i = 0; i < len; i++) begin
            chk("rx wire byte", rx_wire[i], 8'h4c + i[7:0]);
            chk("rx host byte", rx_host[i], 8'h4c + i[7:0]);
            if (clr == 1) chk("rx host addr", rx_addr[i], i[7:0]);
        end
        chk("rx clears", clr_n - c0, clr);
        chk("rx flags", flag_n - f0, flags(len));
        chk("rx error", link.rx_packet_error, errpos < len);
    endtask : rx_packet

    initial begin
        #300000;
        n_mismatch++;
        close_out();
    end

    initial begin
        reset = 1'b1;
        {tx_req_valid, rx_in_valid, rx_in_first, rx_in_error} = 4'h0;
        {load_valid, data_available, engine_reset} = 3'h0;
        tx_out_ready = 1'b1;
        {tx_req_len, rx_in_len} = 32'h00000000;
        {rx_in_data, load_addr, load_data} = 24'h000000;
        {rx_in_sync, sync_mask} = 8'h00;
        repeat (8) @(posedge mclk);
        #1;
        reset = 1'b0;
        step(8);
        for (k = 0; k < 16; k++) load(k[7:0]);
        tx_out_ready = 1'b0;
        tx_start(12);
        repeat (30) @(negedge link.port_clock);
        chk("advances while full", adv_n - a0, ibs_pkg::FIFO_DEPTH);
        step(1);
        tx_collect(12);
        tx_start(6);
        tx_collect(6);
        tx_start(12);
        for (k = 0; k < 800 && adv_n - a0 < 3; k++) step(1);
        engine_reset = 1'b1;
        for (k = 0; k < 40 && tx_active !== 1'b0; k++) step(1);
        chk("abort idle", tx_active, 1'b0);
        chk("abort complete", link.transfer_complete_n, 1'b1);
        chk("abort advance", link.pointer_advance, 1'b0);
        chk("abort early", adv_n - a0 < 12, 1'b1);
        step(40);
        engine_reset = 1'b0;
        step(40);
        tx_start(4);
        tx_collect(4);
        sync_mask = 4'h6;
        rx_packet(9, 4'h2, 99, 1);
        engine_reset = 1'b1;
        step(40);
        rx_packet(5, 4'h9, 2, 0);
        chk("rx under engine reset", rx_host.size(), 5);
        engine_reset = 1'b0;
        step(40);
        close_out();
    end
endmodule : test_isochronous_byte_stream_port
